// ===== pkg/rwi_pkg.sv
package rwi_pkg;
    localparam int RWI_NREG  = 37;
    localparam int RWI_ADR_W = 12;
    localparam int RWI_PC_W  = 13;
    localparam logic [12:0] RWI_IRQ_VECTOR = 13'h0004;
    localparam logic [3:0]  RWI_MSK_MODE   = 4'h9;

    // Entry indexes of the register table
    localparam int RWI_IX_CORE_IRQ_CONTROL = 0;
    localparam int RWI_IX_PERIPHERAL_IRQ_REQUEST1   = 1;
    localparam int RWI_IX_SERIAL_PORT_CONTROL = 2;
    localparam int RWI_IX_RESH   = 5;
    localparam int RWI_IX_PORT_A_DIRECTION  = 8;
    localparam int RWI_IX_PORT_E_DIRECTION  = 12;
    localparam int RWI_IX_POWER_CONTROL_STATUS   = 15;
    localparam int RWI_IX_OSC    = 16;
    localparam int RWI_IX_PR2    = 19;
    localparam int RWI_IX_SADR   = 20;
    localparam int RWI_IX_SMSK   = 21;
    localparam int RWI_IX_RESL   = 32;

    // Field positions
    localparam int RWI_GIE_BIT  = 7;
    localparam int RWI_BOR_BIT  = 0;
    localparam int RWI_OSTS_BIT = 3;
    localparam int RWI_ADIF_BIT = 6;
    localparam int RWI_EV_POR   = 0;
    localparam int RWI_EV_BOR   = 1;
    localparam int RWI_EV_PIN   = 2;
    localparam int RWI_EV_WDT   = 3;
    localparam int RWI_EV_WAKE  = 4;
    localparam int RWI_EV_VEC   = 5;

    // Word indexes; byte address is four times these
    localparam logic [9:0] RWI_IX_EVST = 10'h01F0;
    localparam logic [9:0] RWI_IX_EVMK = 10'h01F1;
    localparam logic [9:0] RWI_IX_PCLO = 10'h01F2;
    localparam logic [9:0] RWI_IX_PCHI = 10'h01F3;

    localparam logic [9:0] RWI_OFS [RWI_NREG] = '{
        10'h000B, 10'h000C, 10'h0014, 10'h001C, 10'h001D, 10'h001E, 10'h001F, 10'h0081,
        10'h0085, 10'h0086, 10'h0087, 10'h0088, 10'h0089, 10'h008C, 10'h008D, 10'h008E,
        10'h008F, 10'h0090, 10'h0091, 10'h0092, 10'h0093, 10'h0093, 10'h0094, 10'h0095,
        10'h0096, 10'h0097, 10'h0098, 10'h0099, 10'h009A, 10'h009B, 10'h009C, 10'h009D,
        10'h009E, 10'h009F, 10'h0105, 10'h0107, 10'h0108};
    localparam logic [7:0] RWI_POR [RWI_NREG] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'h0F, 8'h00, 8'h00, 8'h10, 8'h60, 8'h00, 8'h00, 8'hFF,
        8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h01, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00};
    localparam logic [7:0] RWI_MASK [RWI_NREG] = '{
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hDF, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h33, 8'h7F, 8'h1F, 8'hFF, 8'hFF,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF7, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'h1F, 8'hFF, 8'hB0, 8'h1F, 8'hFB, 8'hFB};
    // Bits left unchanged by pin, watchdog and brown-out resets, except power status bit 0, which brown-out clears
    localparam logic [7:0] RWI_KEEP [RWI_NREG] = '{
        8'h01, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h13, 8'h00, 8'h1F, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};

    typedef struct packed {
        logic por;
        logic bor;
        logic pin;
        logic wdt;
    } rwi_rst_t;

    typedef struct packed {
        logic       valid;
        logic       by_wdt;
        logic [2:0] core_flags;
        logic [7:0] periph_flags;
    } rwi_wake_t;

    typedef struct packed {
        logic                 cyc;
        logic                 stb;
        logic                 we;
        logic [3:0]           sel;
        logic [RWI_ADR_W-1:0] adr;
        logic [31:0]          dat;
    } rwi_wb_req_t;

    typedef struct packed {
        logic [RWI_NREG-1:0][7:0] bank;
        logic [RWI_PC_W-1:0]      pc;
        logic                     pc_load;
        logic [7:0]               evst;
        logic [7:0]               evmk;
        logic                     ack;
        logic [31:0]              rdat;
    } rwi_state_t;
endpackage

// ===== hw/rwi_regbank.sv
// What this block does
// - Interrupt wake with enable loads vector 0004h
// - Brown-out reset clears power status bit 0
// - Pin and watchdog resets keep power status bit 0
// - Address 93h shows mask only in mode 1001
// - Wake sets matching core or peripheral flags
// - Power-on reset loads power-on values
// - Unimplemented bits read zero, conditional bits loaded
// - Every reset clears global interrupt enable
// - Flags set regardless of any enable
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/100ps
module rwi_regbank (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // Wishbone slave
    input  wire rwi_pkg::rwi_wb_req_t       wb_i,
    output logic [31:0]                     wb_dat_o,
    output logic                            wb_ack_o,
    // Reset causes and wake-up
    input  wire rwi_pkg::rwi_rst_t          rst_src_i,
    input  wire rwi_pkg::rwi_wake_t         wake_i,
    input  wire logic [12:0]                core_pc_i,
    input  wire logic                       osc_stable_i,
    // Flag events
    input  wire logic [2:0]                 core_evt_i,
    input  wire logic [7:0]                 periph_evt_i,
    input  wire logic                       conv_done_i,
    input  wire logic [15:0]                conv_result_i,
    // Core side
    output logic [12:0]                     pc_o,
    output logic                            pc_load_o,
    output logic                            gie_o,
    output logic [3:0]                      serial_mode_o,
    output logic                            irq_o
);
    import rwi_pkg::*;

    rwi_state_t cur_reg;
    rwi_state_t cur_next;

    logic       req;
    logic       done;
    logic       any_rst;
    logic       por;
    logic       msk_sel;
    logic [9:0] widx;
    logic [6:0] look;
    logic       evst_rd;

    function automatic logic [6:0] rwi_find(
        input logic [9:0] ix,
        input logic       mask_mode
    );
        logic [6:0] r;
        r = 7'h00;
        for (int i = 0; i < RWI_NREG; i++) begin
            if (RWI_OFS[i] == ix) begin
                // One address, two registers, picked by mode
                if (!((i == RWI_IX_SADR) && mask_mode) &&
                    !((i == RWI_IX_SMSK) && !mask_mode)) begin
                    r = {1'b1, 6'(i)};
                end
            end
        end
        return r;
    endfunction

    function automatic logic rwi_ro(input int i);
        return (i == RWI_IX_RESH) || (i == RWI_IX_RESL);
    endfunction

    assign req     = wb_i.cyc & wb_i.stb;
    assign done    = req & cur_reg.ack;
    assign por     = rst_i | rst_src_i.por;
    assign any_rst = por | rst_src_i.bor | rst_src_i.pin | rst_src_i.wdt;
    assign widx    = wb_i.adr[RWI_ADR_W-1:2];
    assign msk_sel = cur_reg.bank[RWI_IX_SERIAL_PORT_CONTROL][3:0] == RWI_MSK_MODE;
    assign look    = rwi_find(widx, msk_sel);
    assign evst_rd = done && !wb_i.we && !look[6] && (widx == RWI_IX_EVST);

    always_comb begin
        cur_next = cur_reg;
        cur_next.pc_load = 1'b0;
        cur_next.rdat = 32'h0000_0000;
        // Single wait state; ack drops the cycle after it is given
        cur_next.ack = req & ~cur_reg.ack;

        if (req && !cur_reg.ack && !wb_i.we) begin
            if (look[6]) begin
                cur_next.rdat = {24'h00_0000, cur_reg.bank[look[5:0]]};
            end else begin
                case (widx)
                    RWI_IX_EVST: cur_next.rdat = {24'h00_0000, cur_reg.evst};
                    RWI_IX_EVMK: cur_next.rdat = {24'h00_0000, cur_reg.evmk};
                    RWI_IX_PCLO: cur_next.rdat = {24'h00_0000, cur_reg.pc[7:0]};
                    RWI_IX_PCHI: cur_next.rdat = {27'h000_0000, cur_reg.pc[12:8]};
                    default:     cur_next.rdat = 32'h0000_0000;
                endcase
            end
        end

        // Writes land at the edge where the master sees ack
        if (done && wb_i.we && wb_i.sel[0]) begin
            for (int i = 0; i < RWI_NREG; i++) begin
                if (look[6] && (look[5:0] == 6'(i)) && !rwi_ro(i)) begin
                    cur_next.bank[i] = wb_i.dat[7:0] & RWI_MASK[i];
                end
            end
            if (!look[6] && (widx == RWI_IX_EVMK)) begin
                cur_next.evmk = wb_i.dat[7:0];
            end
        end

        // Clear only what the read reported, so a late event survives
        if (evst_rd) begin
            cur_next.evst = cur_reg.evst & ~cur_reg.rdat[7:0];
        end

        // Hardware sets win over software writes
        cur_next.bank[RWI_IX_CORE_IRQ_CONTROL][2:0] =
            cur_next.bank[RWI_IX_CORE_IRQ_CONTROL][2:0] | core_evt_i;
        cur_next.bank[RWI_IX_PERIPHERAL_IRQ_REQUEST1] =
            cur_next.bank[RWI_IX_PERIPHERAL_IRQ_REQUEST1] | periph_evt_i;
        if (conv_done_i) begin
            cur_next.bank[RWI_IX_RESH] = conv_result_i[15:8];
            cur_next.bank[RWI_IX_RESL] = conv_result_i[7:0];
            cur_next.bank[RWI_IX_PERIPHERAL_IRQ_REQUEST1][RWI_ADIF_BIT] = 1'b1;
        end

        if (wake_i.valid) begin
            // Registers not reloaded on wake keep contents
            cur_next.bank[RWI_IX_PR2]  = RWI_POR[RWI_IX_PR2];
            cur_next.bank[RWI_IX_SMSK] = RWI_POR[RWI_IX_SMSK];
            cur_next.bank[RWI_IX_CORE_IRQ_CONTROL][2:0] =
                cur_next.bank[RWI_IX_CORE_IRQ_CONTROL][2:0] | wake_i.core_flags;
            cur_next.bank[RWI_IX_PERIPHERAL_IRQ_REQUEST1] =
                cur_next.bank[RWI_IX_PERIPHERAL_IRQ_REQUEST1] | wake_i.periph_flags;
            cur_next.pc_load = 1'b1;
            cur_next.evst[RWI_EV_WAKE] = 1'b1;
            if (!wake_i.by_wdt && cur_reg.bank[RWI_IX_CORE_IRQ_CONTROL][RWI_GIE_BIT]) begin
                cur_next.pc = RWI_IRQ_VECTOR;
                cur_next.evst[RWI_EV_VEC] = 1'b1;
            end else begin
                cur_next.pc = core_pc_i + 13'h0001;
            end
        end

        if (por) begin
            for (int i = 0; i < RWI_NREG; i++) begin
                cur_next.bank[i] = RWI_POR[i];
            end
            cur_next.bank[RWI_IX_OSC][RWI_OSTS_BIT] = osc_stable_i;
            cur_next.evst = 8'h00;
            cur_next.evst[RWI_EV_POR] = 1'b1;
            cur_next.evmk = 8'h00;
            cur_next.pc = 13'h0000;
            cur_next.pc_load = 1'b1;
        end else if (any_rst) begin
            for (int i = 0; i < RWI_NREG; i++) begin
                cur_next.bank[i] = (cur_reg.bank[i] & RWI_KEEP[i]) |
                                   (RWI_POR[i] & ~RWI_KEEP[i]);
            end
            cur_next.bank[RWI_IX_OSC][RWI_OSTS_BIT] = osc_stable_i;
            // Bit 0 is in the keep set, so non brown-out resets hold it
            if (rst_src_i.bor) begin
                cur_next.bank[RWI_IX_POWER_CONTROL_STATUS][RWI_BOR_BIT] = 1'b0;
            end
            cur_next.evst[RWI_EV_BOR] = cur_next.evst[RWI_EV_BOR] | rst_src_i.bor;
            cur_next.evst[RWI_EV_PIN] = cur_next.evst[RWI_EV_PIN] | rst_src_i.pin;
            cur_next.evst[RWI_EV_WDT] = cur_next.evst[RWI_EV_WDT] | rst_src_i.wdt;
            cur_next.pc = 13'h0000;
            cur_next.pc_load = 1'b1;
        end

        if (rst_i) begin
            cur_next.ack = 1'b0;
            cur_next.rdat = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        cur_reg <= cur_next;
    end

    assign wb_dat_o      = cur_reg.rdat;
    assign wb_ack_o      = cur_reg.ack;
    assign pc_o          = cur_reg.pc;
    assign pc_load_o     = cur_reg.pc_load;
    assign gie_o         = cur_reg.bank[RWI_IX_CORE_IRQ_CONTROL][RWI_GIE_BIT];
    assign serial_mode_o = cur_reg.bank[RWI_IX_SERIAL_PORT_CONTROL][3:0];
    // Level output, held while any unmasked event is pending
    assign irq_o         = |(cur_reg.evst & cur_reg.evmk);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_VECTOR: assert property (
        wake_i.valid && !wake_i.by_wdt && !any_rst &&
        cur_reg.bank[RWI_IX_CORE_IRQ_CONTROL][RWI_GIE_BIT]
        |=> pc_load_o && (pc_o == RWI_IRQ_VECTOR))
        else $error("interrupt wake did not load vector");

    AST_BOR_CLR: assert property (
        rst_src_i.bor && !rst_src_i.por
        |=> !cur_reg.bank[RWI_IX_POWER_CONTROL_STATUS][RWI_BOR_BIT] && (pc_o == 13'h0000))
        else $error("brown-out did not clear status bit");

    AST_BOR_KEEP: assert property (
        (rst_src_i.pin || rst_src_i.wdt) && !rst_src_i.bor && !rst_src_i.por
        |=> $stable(cur_reg.bank[RWI_IX_POWER_CONTROL_STATUS][RWI_BOR_BIT]))
        else $error("other reset changed status bit");

    AST_ALIAS: assert property (
        req && !cur_reg.ack && !wb_i.we && (widx == RWI_OFS[RWI_IX_SMSK])
        |=> wb_ack_o && (wb_dat_o[7:0] == (msk_sel ?
            cur_reg.bank[RWI_IX_SMSK] : cur_reg.bank[RWI_IX_SADR])))
        else $error("alias read returned wrong register");

    AST_WAKE_FLAG: assert property (
        wake_i.valid && !any_rst
        |=> ((cur_reg.bank[RWI_IX_PERIPHERAL_IRQ_REQUEST1] & $past(wake_i.periph_flags))
             == $past(wake_i.periph_flags)) &&
            ((cur_reg.bank[RWI_IX_CORE_IRQ_CONTROL][2:0] & $past(wake_i.core_flags))
             == $past(wake_i.core_flags)))
        else $error("wake flags not set");

    AST_POR_VAL: assert property (
        rst_src_i.por
        |=> (cur_reg.bank[RWI_IX_PORT_A_DIRECTION] == RWI_POR[RWI_IX_PORT_A_DIRECTION]) &&
            (cur_reg.bank[RWI_IX_POWER_CONTROL_STATUS] == RWI_POR[RWI_IX_POWER_CONTROL_STATUS]) &&
            (cur_reg.evmk == 8'h00))
        else $error("power-on values not loaded");

    AST_UNIMPL: assert property (
        (cur_reg.bank[RWI_IX_PORT_E_DIRECTION] & ~RWI_MASK[RWI_IX_PORT_E_DIRECTION]) == 8'h00 &&
        (cur_reg.bank[RWI_IX_POWER_CONTROL_STATUS] & ~RWI_MASK[RWI_IX_POWER_CONTROL_STATUS]) == 8'h00)
        else $error("unimplemented bit reads one");

    AST_GIE_CLR: assert property (
        any_rst |=> !gie_o ##1 pc_o == 13'h0000 || $past(wake_i.valid))
        else $error("reset left interrupt enable set");

    AST_FLAG_SET: assert property (
        (periph_evt_i != 8'h00) && !any_rst
        |=> (cur_reg.bank[RWI_IX_PERIPHERAL_IRQ_REQUEST1] & $past(periph_evt_i)) == $past(periph_evt_i))
        else $error("peripheral flag not set");

    AST_WAKE_KEEP: assert property (
        wake_i.valid && !any_rst && !req
        |=> $stable(cur_reg.bank[RWI_IX_PORT_A_DIRECTION]) &&
            (cur_reg.bank[RWI_IX_PR2] == RWI_POR[RWI_IX_PR2]))
        else $error("wake altered a held register");

    AST_ACK_PULSE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack stood longer than one cycle");

    AST_ACK_ANSWER: assert property (
        req && !wb_ack_o |=> wb_ack_o)
        else $error("request was not answered");

    AST_RD_HIGH: assert property (
        wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read data not zero");

    AST_RD_IDLE: assert property (
        !wb_ack_o |-> (wb_dat_o == 32'h0000_0000))
        else $error("read data outside ack cycle");

    AST_VEC_SKIP: assert property (
        wake_i.valid && !any_rst && (wake_i.by_wdt || !gie_o)
        |=> pc_load_o && (pc_o == $past(core_pc_i) + 13'h0001))
        else $error("plain wake did not resume at next address");

    AST_VEC_EV: assert property (
        wake_i.valid && !wake_i.by_wdt && gie_o && !any_rst
        |=> cur_reg.evst[RWI_EV_VEC])
        else $error("vector load not recorded");

    AST_BOR_EV: assert property (
        rst_src_i.bor && !por
        |=> cur_reg.evst[RWI_EV_BOR] && !gie_o)
        else $error("brown-out not recorded");

    AST_WAKE_EV: assert property (
        wake_i.valid && !any_rst
        |=> cur_reg.evst[RWI_EV_WAKE])
        else $error("wake not recorded");

    AST_POR_PC: assert property (
        rst_src_i.por
        |=> pc_load_o && (pc_o == 13'h0000) && (cur_reg.evst == 8'h01))
        else $error("power-on reset missed counter or status");

    AST_MASK_HOLD: assert property (
        any_rst && !por && !done
        |=> $stable(cur_reg.evmk))
        else $error("non power-on reset changed event mask");

    AST_RST_PC: assert property (
        any_rst && !por
        |=> pc_load_o && (pc_o == 13'h0000))
        else $error("other reset did not clear program counter");

    AST_PCL_CAUSE: assert property (
        !any_rst && !wake_i.valid |=> !pc_load_o)
        else $error("program counter loaded without a cause");

    AST_OTHER_VAL: assert property (
        any_rst && !por
        |=> (cur_reg.bank[RWI_IX_PORT_E_DIRECTION] == RWI_POR[RWI_IX_PORT_E_DIRECTION]) &&
            (cur_reg.bank[RWI_IX_SERIAL_PORT_CONTROL] == RWI_POR[RWI_IX_SERIAL_PORT_CONTROL]) &&
            (cur_reg.bank[RWI_IX_PR2] == RWI_POR[RWI_IX_PR2]))
        else $error("other reset missed a reload");

    AST_OTHER_KEEP: assert property (
        any_rst && !por
        |=> $stable(cur_reg.bank[RWI_IX_RESH]) && $stable(cur_reg.bank[RWI_IX_RESL]))
        else $error("other reset altered a held register");

    AST_OSC_STS: assert property (
        any_rst
        |=> cur_reg.bank[RWI_IX_OSC][RWI_OSTS_BIT] == $past(osc_stable_i))
        else $error("oscillator status bit not loaded");

    AST_CORE_FLAG: assert property (
        (core_evt_i != 3'b000) && !any_rst
        |=> (cur_reg.bank[RWI_IX_CORE_IRQ_CONTROL][2:0] & $past(core_evt_i)) == $past(core_evt_i))
        else $error("core flag not set");

    AST_CONV: assert property (
        conv_done_i && !any_rst
        |=> cur_reg.bank[RWI_IX_PERIPHERAL_IRQ_REQUEST1][RWI_ADIF_BIT] &&
            (cur_reg.bank[RWI_IX_RESL] == $past(conv_result_i[7:0])))
        else $error("conversion result or flag lost");

    AST_RO_WRITE: assert property (
        done && wb_i.we && (widx == RWI_OFS[RWI_IX_RESH]) && !conv_done_i && !por
        |=> $stable(cur_reg.bank[RWI_IX_RESH]))
        else $error("write reached a read-only register");

    AST_SADR_WR: assert property (
        done && wb_i.we && wb_i.sel[0] && (widx == RWI_OFS[RWI_IX_SADR]) &&
        !msk_sel && !any_rst && !wake_i.valid
        |=> (cur_reg.bank[RWI_IX_SADR] == $past(wb_i.dat[7:0])) && $stable(cur_reg.bank[RWI_IX_SMSK]))
        else $error("address write missed slave address register");

    AST_SMSK_WR: assert property (
        done && wb_i.we && wb_i.sel[0] && (widx == RWI_OFS[RWI_IX_SMSK]) &&
        msk_sel && !any_rst && !wake_i.valid
        |=> (cur_reg.bank[RWI_IX_SMSK] == $past(wb_i.dat[7:0])) && $stable(cur_reg.bank[RWI_IX_SADR]))
        else $error("address write missed mask register");

    AST_EV_STICKY: assert property (
        (cur_reg.evst != 8'h00) && !evst_rd && !por
        |=> (cur_reg.evst & $past(cur_reg.evst)) == $past(cur_reg.evst))
        else $error("event bit dropped without a read");

    // Every table entry, not only the two sampled above
    for (genvar g = 0; g < RWI_NREG; g++) begin : g_unimpl
        AST_UNIMPL_ALL: assert property (@(posedge clk_i) disable iff (rst_i)
            (cur_reg.bank[g] & ~RWI_MASK[g]) == 8'h00)
            else $error("unimplemented bit set in table entry");
    end

    COV_WAKE_VEC: cover property (wake_i.valid ##1 pc_o == RWI_IRQ_VECTOR);
    COV_BOR:      cover property (rst_src_i.bor ##1 !rst_src_i.bor);
    COV_ALIAS:    cover property (msk_sel && req && widx == RWI_OFS[RWI_IX_SMSK]);
    COV_IRQ:      cover property (irq_o ##[1:20] !irq_o);
    COV_SADR_WR:  cover property (done && wb_i.we && !msk_sel && widx == RWI_OFS[RWI_IX_SADR]);
endmodule

// ===== sim/tb_rwi_regbank.sv
`timescale 1ns/100ps
module tb_rwi_regbank;
    import rwi_pkg::*;
    logic              clk_i;
    logic              rst_i;
    rwi_wb_req_t       wb_i;
    logic [31:0]       wb_dat_o;
    logic              wb_ack_o;
    rwi_rst_t          rst_src_i;
    rwi_wake_t         wake_i;
    logic [12:0]       core_pc_i;
    logic              osc_stable_i;
    logic [2:0]        core_evt_i;
    logic [7:0]        periph_evt_i;
    logic              conv_done_i;
    logic [15:0]       conv_result_i;
    logic [12:0]       pc_o;
    logic              pc_load_o;
    logic              gie_o;
    logic [3:0]        serial_mode_o;
    logic              irq_o;
    int                num_errors = 0;
    int                num_checks = 0;
    logic [31:0]       rdq [$];
    logic [12:0]       pcq [$];
    logic [7:0]        r;
    logic [15:0]       cr;
    localparam logic [9:0] PO [19] = '{10'h00B, 10'h01D, 10'h01F, 10'h081, 10'h085, 10'h086, 10'h087,
        10'h088, 10'h089, 10'h08C, 10'h08D, 10'h08F, 10'h092, 10'h093, 10'h095, 10'h098, 10'h09D,
        10'h105, 10'h107};
    localparam logic [7:0] PV [19] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h0F,
        8'h00, 8'h00, 8'h60, 8'hFF, 8'h00, 8'hFF, 8'h02, 8'h01, 8'h08, 8'h00};
    localparam logic [9:0] MO [6] = '{10'h01D, 10'h01F, 10'h089, 10'h090, 10'h09D, 10'h105};
    localparam logic [7:0] MV [6] = '{8'h3F, 8'hDF, 8'h0F, 8'h1F, 8'h1F, 8'h1F};

    rwi_regbank uut (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .wb_i          (wb_i),
        .wb_dat_o      (wb_dat_o),
        .wb_ack_o      (wb_ack_o),
        .rst_src_i     (rst_src_i),
        .wake_i        (wake_i),
        .core_pc_i     (core_pc_i),
        .osc_stable_i  (osc_stable_i),
        .core_evt_i    (core_evt_i),
        .periph_evt_i  (periph_evt_i),
        .conv_done_i   (conv_done_i),
        .conv_result_i (conv_result_i),
        .pc_o          (pc_o),
        .pc_load_o     (pc_load_o),
        .gie_o         (gie_o),
        .serial_mode_o (serial_mode_o),
        .irq_o         (irq_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Classic single cycle, held until ack is sampled, then one idle cycle
    task automatic xfer(input logic w, input logic [9:0] ix, input logic [7:0] d, input logic [7:0] e);
        int n;
        wb_i <= '{1'b1, 1'b1, w, 4'h1, {ix, 2'b00}, {24'h0, d}};
        if (!w) rdq.push_back({24'h0, e});
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1) begin
            num_errors++;
            end_sim();
        end
        wb_i <= '0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [9:0] ix, input logic [7:0] e);
        xfer(1'b0, ix, 8'h00, e);
    endtask

    task automatic wr(input logic [9:0] ix, input logic [7:0] d);
        xfer(1'b1, ix, d, 8'h00);
    endtask

    // Cause index follows the struct order: 0 power-on, 1 brown-out, 2 pin, 3 watchdog
    task automatic cause(input int k);
        pcq.push_back(13'h0000);
        rst_src_i <= rwi_rst_t'(4'h8 >> k);
        @(posedge clk_i);
        rst_src_i <= '0;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic wake(input logic w, input logic [2:0] cf, input logic [7:0] pf, input logic vec);
        logic [12:0] p;
        p = 13'($urandom);
        core_pc_i <= p;
        pcq.push_back(vec ? 13'h0004 : p + 13'h0001);
        wake_i <= '{1'b1, w, cf, pf};
        @(posedge clk_i);
        wake_i <= '0;
        repeat (2) @(posedge clk_i);
    endtask

    // Scoreboard: oldest note against each result as it appears
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && !wb_i.we && rdq.size() > 0) chk(wb_dat_o, rdq.pop_front());
        if (pc_load_o === 1'b1 && pcq.size() > 0) chk({19'h0, pc_o}, {19'h0, pcq.pop_front()});
    end

    initial begin
        rst_i = 1'b1;
        wb_i = '0;
        rst_src_i = '0;
        wake_i = '0;
        core_pc_i = '0;
        osc_stable_i = 1'b0;
        core_evt_i = '0;
        periph_evt_i = '0;
        conv_done_i = 1'b0;
        conv_result_i = '0;
        void'($urandom(70));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (PO[i]) rd(PO[i], PV[i]);
        rd(10'h1F0, 8'h01);
        foreach (MO[i]) begin
            r = 8'($urandom);
            wr(MO[i], r);
            rd(MO[i], r & MV[i]);
        end
        wr(10'h1F1, 8'h04);
        for (int k = 1; k < 4; k++) begin
            r = 8'($urandom);
            wr(10'h085, r);
            wr(10'h01C, r);
            wr(10'h08E, 8'h01);
            wr(10'h00B, 8'h80);
            chk(gie_o, 1'b1);
            cause(k);
            chk(gie_o, 1'b0);
            chk(irq_o, k == 2);
            rd(10'h085, 8'hFF);
            rd(10'h01C, r);
            rd(10'h08E, (k == 1) ? 8'h00 : 8'h01);
            rd(10'h1F0, 8'h01 << k);
            chk(irq_o, 1'b0);
        end
        // Address 93h switches with the serial mode field
        wr(10'h014, 8'h09);
        chk(serial_mode_o, 4'h9);
        rd(10'h093, 8'hFF);
        wr(10'h093, 8'h5A);
        wr(10'h014, 8'h08);
        rd(10'h093, 8'h00);
        wr(10'h093, 8'h33);
        wr(10'h014, 8'h09);
        rd(10'h093, 8'h5A);
        wr(10'h092, 8'h12);
        wr(10'h085, 8'h3C);
        wr(10'h00B, 8'h80);
        wake(1'b0, 3'b010, 8'h04, 1'b1);
        rd(10'h00B, 8'h82);
        rd(10'h00C, 8'h04);
        rd(10'h092, 8'hFF);
        rd(10'h093, 8'hFF);
        rd(10'h085, 8'h3C);
        rd(10'h1F0, 8'h30);
        rd(10'h1F2, 8'h04);
        rd(10'h1F3, 8'h00);
        wr(10'h00B, 8'h00);
        wake(1'b0, 3'b100, 8'h01, 1'b0);
        rd(10'h00B, 8'h04);
        wake(1'b1, 3'b000, 8'h00, 1'b0);
        rd(10'h1F0, 8'h10);
        wr(10'h00B, 8'h00);
        wr(10'h00C, 8'h00);
        cr = 16'($urandom);
        core_evt_i <= 3'b001;
        periph_evt_i <= 8'h80;
        conv_done_i <= 1'b1;
        conv_result_i <= cr;
        @(posedge clk_i);
        core_evt_i <= '0;
        periph_evt_i <= '0;
        conv_done_i <= 1'b0;
        @(posedge clk_i);
        rd(10'h00B, 8'h01);
        rd(10'h00C, 8'hC0);
        wr(10'h01E, 8'hFF);
        rd(10'h01E, cr[15:8]);
        rd(10'h09E, cr[7:0]);
        wr(10'h3FF, 8'hA5);
        rd(10'h3FF, 8'h00);
        osc_stable_i <= 1'b1;
        cause(0);
        rd(10'h01C, 8'h00);
        rd(10'h1F1, 8'h00);
        rd(10'h085, 8'hFF);
        rd(10'h08F, 8'h68);
        repeat (2) @(posedge clk_i);
        chk(rdq.size(), 0);
        chk(pcq.size(), 0);
        end_sim();
    end
endmodule
